// ---- rtl/asr_pkg.sv ----
// Purpose: constants for the host-side controller of a 512K x 16 asynchronous static RAM
// Assumes: 200 MHz system clock (5 ns period); slower speed grade timings used throughout
// Notes: every minimum time, and the lane release maximum, rounds up to whole cycles
package asr_pkg;
  // clock period in picoseconds
  localparam int CLK_PERIOD_PS = 5000;
  // word address and data widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // slower grade timing figures, in ns
  localparam int READ_CYCLE_MIN_NS = 55;
  localparam int ADDR_ACCESS_MAX_NS = 55;
  localparam int GATE_TO_VALID_MAX_NS = 25;
  localparam int LANE_TO_VALID_MAX_NS = 55;
  localparam int LANE_RELEASE_MAX_NS = 20;
  localparam int ADDR_SETUP_TO_END_NS = 40;
  localparam int LANE_LOW_TO_END_NS = 40;
  localparam int STROBE_PULSE_MIN_NS = 40;
  localparam int WDATA_SETUP_NS = 25;
  localparam int WDATA_HOLD_NS = 0;
  localparam int STROBE_TO_FLOAT_NS = 20;
  localparam int RETENTION_RECOVERY_NS = 55;
  // power-up wait, in us
  localparam int POWER_UP_WAIT_US = 200;
  // round a minimum time up to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  // read: address stable and gates low until data valid and cycle time met
  localparam int READ_WAIT_CYC = cyc_min(READ_CYCLE_MIN_NS);
  // lane or gate release before the bus can be driven again
  localparam int FLOAT_CYC = cyc_min(LANE_RELEASE_MAX_NS);
  // write strobe low time: larger of pulse and setup+float
  localparam int WR_SUM_NS = WDATA_SETUP_NS + STROBE_TO_FLOAT_NS;
  localparam int WR_PULSE_NS = (WR_SUM_NS > STROBE_PULSE_MIN_NS) ? WR_SUM_NS
                               : STROBE_PULSE_MIN_NS;
  localparam int WRITE_WAIT_CYC = cyc_min(WR_PULSE_NS);
  // data hold after strobe rises, at least one cycle
  localparam int WHOLD_CYC = cyc_min(WDATA_HOLD_NS);
  // recovery wait after retention
  localparam int RECOVER_CYC = cyc_min(RETENTION_RECOVERY_NS);
  // power-up count, 200 us at 5 ns = 40000 cycles
  localparam int POWER_UP_CYC = (POWER_UP_WAIT_US * 1000000) / CLK_PERIOD_PS;
  // counter width
  localparam int CNT_W = 16;
  // sequencer states
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_WHOLD,
    ST_FLOAT,
    ST_RETAIN,
    ST_RECOVER
  } asr_state_type;
endpackage

// ---- rtl/asr_timer.sv ----
// Purpose: down counter that flags when a loaded cycle count has elapsed
// Assumes: load and count on one clock
// Notes: done is high while the count stands at zero
`timescale 1ns/100ps
module asr_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [asr_pkg::CNT_W-1:0] value,
  output logic done
);
  // remaining cycles
  logic [asr_pkg::CNT_W-1:0] cnt_q;
  // load or count down to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  // elapsed flag
  assign done = (cnt_q == '0);
endmodule

// ---- rtl/asr_host.sv ----
// Purpose: host controller driving an asynchronous 512K x 16 static RAM by its pins
// Assumes: 200 MHz clock; slower grade figures; read data sampled on the same clock
// Notes on behaviour
// - write happens only while all selects active
// - write data stable 25 ns before end
// - read data valid after access; cycle spacing
// - write address stable 40 ns before end
// - address fixed from start to end
// - lane and strobe low 40 ns minimum
// - strobe pulse covers setup plus float
// - deselect by selects or both lanes high
// - wait recovery time after retention
// - wait 200 us after power-up
// - strobe high throughout every read
`timescale 1ns/100ps
module asr_host #(
  // power-up wait in cycles, shortened in simulation
  parameter int POWER_UP_CYCLES = asr_pkg::POWER_UP_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [asr_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [asr_pkg::DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_LANES,
  output logic RSP_VALID,
  output logic [asr_pkg::DATA_W-1:0] RSP_RDATA,
  input wire logic RETAIN_REQ,
  output logic RETAIN_ACK,
  output logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic SELECT_LOW_ACTIVE_N,
  output logic SELECT_HIGH_ACTIVE,
  output logic WRITE_STROBE_N,
  output logic READ_GATE_N,
  output logic UPPER_BYTE_GATE_N,
  output logic LOWER_BYTE_GATE_N,
  input wire logic [asr_pkg::DATA_W-1:0] MEM_DQ_IN,
  output logic [asr_pkg::DATA_W-1:0] MEM_DQ_OUT,
  output logic MEM_DQ_OE
);
  // sequencer state
  asr_pkg::asr_state_type state_q, state_d;
  // pin registers
  // word address, held from take to the next take
  logic [asr_pkg::ADDR_W-1:0] addr_q;
  // write data driven out and read data handed back
  logic [asr_pkg::DATA_W-1:0] wdata_q, rdata_q;
  // lanes of the access, bit 1 upper and bit 0 lower
  logic [1:0] lanes_q;
  // select, strobe, gate, data enable, answer and kind of access
  logic sel_q, we_q, oe_q, dq_oe_q, rsp_q, is_wr_q;
  // power-up wait counter, free of the shared timer
  logic [31:0] pwr_cnt_q;
  // high once the supply wait is over
  logic pwr_done;
  // three-stage synchroniser for the read data pins
  logic [asr_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
  // retention request is synchronous to CLK
  // timer control
  // done is high while the count stands at zero
  logic tmr_load, tmr_done;
  logic [asr_pkg::CNT_W-1:0] tmr_value;
  // request accepted this cycle
  logic take;
  // decode of a retain request while idle
  logic go_retain;

  // lane mask decode, active low pins per lane
  // a set lane bit gives a low pin
  function automatic logic [1:0] lane_pins(input logic [1:0] lanes);
    return ~lanes;
  endfunction

  // cycle timer shared by every wait except the supply wait
  // it reads zero after reset, so it cannot time the supply wait
  // loads come from the next-state logic only
  asr_timer u_timer (
    .clk(CLK),
    .rst(SYS_RST),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  // handshakes
  // ready only when idle and no retention is asked
  assign REQ_READY = (state_q == asr_pkg::ST_IDLE) && !RETAIN_REQ;
  // a request with no lane enabled is left waiting
  assign take = REQ_VALID && REQ_READY && (REQ_LANES != 2'b00);
  // retention wins over a request in the same cycle
  assign go_retain = (state_q == asr_pkg::ST_IDLE) && RETAIN_REQ;

  // next state and timer loads
  // each wait loads one less, the loading edge counts as a cycle
  always_comb begin
    // defaults: stay, no load
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_value = '0;
    case (state_q)
      asr_pkg::ST_POWERUP: begin
        // no access until the supply wait has elapsed
        if (pwr_done) begin
          state_d = asr_pkg::ST_IDLE;
        end
      end
      // idle: deselected, accept request or retention
      asr_pkg::ST_IDLE: begin
        if (go_retain) begin
          state_d = asr_pkg::ST_RETAIN;
        end else if (take && REQ_WRITE) begin
          state_d = asr_pkg::ST_WRITE;
          tmr_load = 1'b1;
          tmr_value = asr_pkg::CNT_W'(asr_pkg::WRITE_WAIT_CYC - 1);
        end else if (take) begin
          // gate and lanes fall together with the selects
          // read cycle spacing
          state_d = asr_pkg::ST_READ;
          tmr_load = 1'b1;
          tmr_value = asr_pkg::CNT_W'(asr_pkg::READ_WAIT_CYC - 1);
        end
      end
      // read: wait the read cycle time, no synchroniser cycles added
      // read data settles in the synchroniser meanwhile
      asr_pkg::ST_READ: begin
        if (tmr_done) begin
          state_d = asr_pkg::ST_FLOAT;
          tmr_load = 1'b1;
          tmr_value = asr_pkg::CNT_W'(asr_pkg::FLOAT_CYC - 1);
        end
      end
      // write: strobe low for the pulse time
      asr_pkg::ST_WRITE: begin
        if (tmr_done) begin
          state_d = asr_pkg::ST_WHOLD;
          tmr_load = 1'b1;
          tmr_value = asr_pkg::CNT_W'(asr_pkg::WHOLD_CYC - 1);
        end
      end
      // write end: strobe high, data and address held
      // one cycle with strobe high covers the zero data hold
      asr_pkg::ST_WHOLD: begin
        if (tmr_done) begin
          state_d = asr_pkg::ST_IDLE;
        end
      end
      // bus release after a read
      // four cycles cover the lane release time
      asr_pkg::ST_FLOAT: begin
        if (tmr_done) begin
          state_d = asr_pkg::ST_IDLE;
        end
      end
      // retention: deselected until request drops
      // pins stay deselected while parked here
      asr_pkg::ST_RETAIN: begin
        if (!RETAIN_REQ) begin
          state_d = asr_pkg::ST_RECOVER;
          tmr_load = 1'b1;
          tmr_value = asr_pkg::CNT_W'(asr_pkg::RECOVER_CYC - 1);
        end
      end
      // recovery before any access
      // eleven cycles cover the recovery time
      asr_pkg::ST_RECOVER: begin
        if (tmr_done) begin
          state_d = asr_pkg::ST_IDLE;
        end
      end
      // unused codes fall back to idle
      default: begin
        state_d = asr_pkg::ST_IDLE;
      end
    endcase
  end

  // state register; reset enters the power-up state
  // the sequencer waits out the supply time first
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= asr_pkg::ST_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  // power-up timer runs off its own count
  // the count stops once the wait is met, so it never wraps
  assign pwr_done = (pwr_cnt_q >= 32'(POWER_UP_CYCLES));
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pwr_cnt_q <= '0;
    end else if (!pwr_done) begin
      pwr_cnt_q <= pwr_cnt_q + 32'h1;
    end
  end

  // address, data and lane capture on request
  // lanes and kind are kept for the whole access
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_q <= '0;
      wdata_q <= '0;
      lanes_q <= 2'b00;
      is_wr_q <= 1'b0;
    end else if (take) begin
      addr_q <= REQ_ADDR;
      wdata_q <= REQ_WDATA;
      lanes_q <= REQ_LANES;
      is_wr_q <= REQ_WRITE;
    end
  end

  // control pins, registered
  // every pin follows the next state, so all move on one edge
  // strobe, selects and lanes thus end a write together
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sel_q <= 1'b0;
      we_q <= 1'b0;
      oe_q <= 1'b0;
      dq_oe_q <= 1'b0;
    end else begin
      sel_q <= (state_d == asr_pkg::ST_READ) || (state_d == asr_pkg::ST_WRITE);
      // strobe low only in write pulse
      we_q <= (state_d == asr_pkg::ST_WRITE);
      oe_q <= (state_d == asr_pkg::ST_READ);
      // drive data through write and hold
      dq_oe_q <= (state_d == asr_pkg::ST_WRITE) || (state_d == asr_pkg::ST_WHOLD);
    end
  end

  // read data synchroniser, three stages
  // only the second and third stages are compared downstream
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      dq_s1_q <= MEM_DQ_IN;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // read capture at end of read cycle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= '0;
      rsp_q <= 1'b0;
    end else begin
      // sample after valid delay
      // answer pulse lasts one cycle
      rsp_q <= (state_q == asr_pkg::ST_READ) && tmr_done;
      // a word still settling on the pins is not taken
      if ((state_q == asr_pkg::ST_READ) && tmr_done && (dq_s2_q == dq_s3_q)) begin
        rdata_q <= {lanes_q[1] ? dq_s3_q[15:8] : 8'h00, lanes_q[0] ? dq_s3_q[7:0] : 8'h00};
      end
    end
  end

  // pin outputs
  // address straight from its register
  assign MEM_ADDR = addr_q;
  // both selects from one flip-flop, so they never disagree
  assign SELECT_LOW_ACTIVE_N = ~sel_q;
  assign SELECT_HIGH_ACTIVE = sel_q;
  // strobe and gate are active low
  assign WRITE_STROBE_N = ~we_q;
  assign READ_GATE_N = ~oe_q;
  assign {UPPER_BYTE_GATE_N, LOWER_BYTE_GATE_N} = sel_q ? lane_pins(lanes_q) : 2'b11;
  // write data from its register, driven only for writes
  assign MEM_DQ_OUT = wdata_q;
  assign MEM_DQ_OE = dq_oe_q && is_wr_q;
  // answer and data from flip-flops
  assign RSP_VALID = rsp_q;
  assign RSP_RDATA = rdata_q;
  // retention seen while the sequencer parks there
  assign RETAIN_ACK = (state_q == asr_pkg::ST_RETAIN);
endmodule

// ---- test/asr_chk.sv ----
// Purpose: pin protocol checks for asr_host
// Assumes: one clock, async active-high reset
// Notes: bound to every asr_host
`timescale 1ns/100ps
module asr_chk #(
  parameter int POWER_UP_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RSP_VALID,
  input wire logic RETAIN_ACK,
  input wire logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
  input wire logic SELECT_LOW_ACTIVE_N,
  input wire logic SELECT_HIGH_ACTIVE,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_GATE_N,
  input wire logic UPPER_BYTE_GATE_N,
  input wire logic LOWER_BYTE_GATE_N,
  input wire logic [asr_pkg::DATA_W-1:0] MEM_DQ_OUT,
  input wire logic MEM_DQ_OE
);
  // cycles since reset and since last read start
  logic [15:0] up_q;
  logic [3:0] rd_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // saturating counters
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      up_q <= 16'h0000;
      rd_q <= 4'hF;
    end else begin
      up_q <= (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
      rd_q <= $fell(READ_GATE_N) ? 4'h1 : ((rd_q == 4'hF) ? rd_q : rd_q + 4'h1);
    end
  end
  write_qual_a: assert property ($fell(WRITE_STROBE_N) |->
    !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE && MEM_DQ_OE
    && !(UPPER_BYTE_GATE_N && LOWER_BYTE_GATE_N)) else $error("write start unqualified");
  write_pulse_a: assert property ($fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N[*8])
    else $error("write strobe too short");
  wdata_hold_a: assert property (!WRITE_STROBE_N |=> $stable(MEM_DQ_OUT) && MEM_DQ_OE)
    else $error("write data moved");
  waddr_hold_a: assert property (!WRITE_STROBE_N |=> $stable(MEM_ADDR)
    && (WRITE_STROBE_N || $stable({UPPER_BYTE_GATE_N, LOWER_BYTE_GATE_N})))
    else $error("write address moved");
  gate_in_write_a: assert property (!WRITE_STROBE_N |-> READ_GATE_N)
    else $error("gate low in write");
  read_strobe_a: assert property (!READ_GATE_N |-> WRITE_STROBE_N)
    else $error("strobe low in read");
  read_len_a: assert property ($fell(READ_GATE_N) |=>
    (!READ_GATE_N && $stable(MEM_ADDR))[*7] ##[1:4] ($rose(READ_GATE_N) && RSP_VALID))
    else $error("read cycle shape wrong");
  read_space_a: assert property ($fell(READ_GATE_N) |-> rd_q >= 4'hB)
    else $error("reads too close");
  retain_off_a: assert property (RETAIN_ACK |-> !MEM_DQ_OE && (SELECT_LOW_ACTIVE_N
    || !SELECT_HIGH_ACTIVE || (UPPER_BYTE_GATE_N && LOWER_BYTE_GATE_N)))
    else $error("not deselected");
  recover_a: assert property ($fell(RETAIN_ACK) |-> (WRITE_STROBE_N && READ_GATE_N)[*8])
    else $error("access during recovery");
  power_up_a: assert property (!(WRITE_STROBE_N && READ_GATE_N) |->
    up_q >= POWER_UP_CYCLES) else $error("access before power-up wait");
  // main scenarios seen
  cover property ($fell(WRITE_STROBE_N));
  cover property (RSP_VALID);
  cover property ($fell(RETAIN_ACK));
endmodule
bind asr_host asr_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .RSP_VALID(RSP_VALID), .RETAIN_ACK(RETAIN_ACK), .MEM_ADDR(MEM_ADDR),
  .SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N), .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE),
  .WRITE_STROBE_N(WRITE_STROBE_N), .READ_GATE_N(READ_GATE_N),
  .UPPER_BYTE_GATE_N(UPPER_BYTE_GATE_N), .LOWER_BYTE_GATE_N(LOWER_BYTE_GATE_N),
  .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE));

// ---- test/asr_sram_model.sv ----
// Purpose: behavioural 512K x 16 static RAM on the host pins
// Assumes: no clock; read data settles after a fixed delay
// Notes: released lanes show the inverse of their last level
`timescale 1ns/100ps
module asr_sram_model #(
  parameter int DLY = 20
) (
  input wire logic [18:0] addr,
  input wire logic sel_low_n,
  input wire logic sel_high,
  input wire logic strobe_n,
  input wire logic gate_n,
  input wire logic upper_n,
  input wire logic lower_n,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out = 16'h0F0F
);
  // sparse storage, unwritten words read zero
  logic [15:0] mem [int];
  logic sel;
  logic [1:0] wr, rd;
  logic [15:0] wrd, nxt;
  // selected only with both selects active
  assign sel = !sel_low_n && sel_high;
  // write lanes only on full overlap
  assign wr = {2{sel && !strobe_n}} & ~{upper_n, lower_n};
  assign rd = {2{sel && !gate_n && strobe_n}} & ~{upper_n, lower_n};
  // store enabled lanes while the write lasts
  always @(addr, dq_in, wr) begin
    wrd = mem.exists(addr) ? mem[addr] : 16'h0000;
    if (wr[1]) wrd[15:8] = dq_in[15:8];
    if (wr[0]) wrd[7:0] = dq_in[7:0];
    if (wr != 2'b00) mem[addr] = wrd;
  end
  // drive or release after the delay
  always @(addr, rd) begin
    nxt = mem.exists(addr) ? mem[addr] : 16'h0000;
    nxt[15:8] = rd[1] ? nxt[15:8] : ~dq_out[15:8];
    nxt[7:0] = rd[0] ? nxt[7:0] : ~dq_out[7:0];
    dq_out <= #DLY nxt;
  end
endmodule

// ---- test/asr_host_test.sv ----
// Purpose: self-checking bench for asr_host with a memory model
// Assumes: 200 MHz clock, short power-up count
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module asr_host_test;
  localparam int PU = 20;
  logic clk, rst, req_valid, req_write, retain_req;
  logic [18:0] req_addr;
  logic [15:0] req_wdata;
  logic [1:0] req_lanes;
  wire logic req_ready, rsp_valid, retain_ack, sel_n, sel_h, ws_n, rg_n, ub_n, lb_n, dq_oe;
  wire logic [15:0] rsp_rdata, dq_out, mdl_dq, dq_bus;
  wire logic [18:0] mem_addr;
  int n_errors, n_compared, cyc, first_acc;
  // bus level: host when enabled, else the model
  assign dq_bus = dq_oe ? dq_out : mdl_dq;
  asr_host #(.POWER_UP_CYCLES(PU)) dut (.CLK(clk), .SYS_RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_LANES(req_lanes), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
    .RETAIN_REQ(retain_req), .RETAIN_ACK(retain_ack), .MEM_ADDR(mem_addr),
    .SELECT_LOW_ACTIVE_N(sel_n), .SELECT_HIGH_ACTIVE(sel_h), .WRITE_STROBE_N(ws_n),
    .READ_GATE_N(rg_n), .UPPER_BYTE_GATE_N(ub_n), .LOWER_BYTE_GATE_N(lb_n),
    .MEM_DQ_IN(dq_bus), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE(dq_oe));
  asr_sram_model mdl (.addr(mem_addr), .sel_low_n(sel_n), .sel_high(sel_h), .strobe_n(ws_n),
    .gate_n(rg_n), .upper_n(ub_n), .lower_n(lb_n), .dq_in(dq_bus), .dq_out(mdl_dq));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cycle count, first access, hang limit
  always @(posedge clk) begin
    cyc++;
    if (first_acc < 0 && !rst && !(ws_n && rg_n)) first_acc = cyc;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, held until taken
  task automatic req(input logic w, input logic [18:0] a, input logic [15:0] d,
    input logic [1:0] l);
    int n;
    @(posedge clk) #1;
    {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
    for (n = 0; req_ready !== 1'b1 && n < 300; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
  endtask
  // read and compare the answer
  task automatic rd(input logic [18:0] a, input logic [1:0] l, input logic [15:0] exp);
    int n;
    req(1'b0, a, 16'h0000, l);
    for (n = 0; rsp_valid !== 1'b1 && n < 30; n++) @(posedge clk) #1;
    chk(rsp_rdata, exp);
  endtask
  task automatic t_powerup();
    req(1'b1, 19'h7FFFF, 16'hA5C3, 2'b11);
    rd(19'h7FFFF, 2'b11, 16'hA5C3);
    chk(16'(first_acc >= PU), 16'h0001);
  endtask
  task automatic t_lanes();
    req(1'b1, 19'h00000, 16'h1234, 2'b11);
    req(1'b1, 19'h00000, 16'hABCD, 2'b10);
    rd(19'h00000, 2'b11, 16'hAB34);
    rd(19'h00000, 2'b01, 16'h0034);
    rd(19'h00000, 2'b10, 16'hAB00);
    req(1'b1, 19'h00001, 16'h5566, 2'b01);
    rd(19'h00001, 2'b11, 16'h0066);
  endtask
  // no lane enabled: never taken
  task automatic t_refuse();
    int n;
    @(posedge clk) #1;
    {req_valid, req_write, req_lanes} = 4'b1100;
    for (n = 0; n < 6; n++) begin
      @(posedge clk) #1;
      chk({15'h0000, ws_n & rg_n}, 16'h0001);
    end
    req_valid = 1'b0;
  endtask
  task automatic t_retain();
    int n;
    @(posedge clk) #1;
    retain_req = 1'b1;
    for (n = 0; retain_ack !== 1'b1 && n < 50; n++) @(posedge clk) #1;
    chk({14'h0000, retain_ack, req_ready}, 16'h0002);
    retain_req = 1'b0;
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(posedge clk) #1;
    chk(16'(n >= 11), 16'h0001);
    rd(19'h00000, 2'b11, 16'hAB34);
  endtask
  task automatic end_sim();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // reset, then scenarios
  initial begin
    {rst, req_valid, req_write, retain_req, req_lanes} = 6'b100000;
    {req_addr, req_wdata} = 35'h0;
    {n_errors, n_compared, cyc, first_acc} = {32'd0, 32'd0, 32'd0, -32'sd1};
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    cyc = 0;
    t_powerup();
    t_lanes();
    t_refuse();
    t_retain();
    end_sim();
  end
endmodule
